// >>> rtl/mszd_standstill.v
// Motor standstill detector: two hysteresis comparators against a zero
// level, a combined stopped flag, the stop-hold quench and an AHB-Lite
// register slave with a sticky interrupt.
// Assumes speed inputs are synchronous to clk, in hundredths of a percent.
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`include "mszd_defines.vh"
`default_nettype none

// How it works
// - Speed flag set below zero level, hysteresis.
// - Demand flag set below zero level, hysteresis.
// - Stopped flag equals both near-zero flags.
// - Stopped with hold enabled quenches both loops.
// - Hold inhibits firing, keeps contactor and lamp.
// - Hold lasts until either input rises.
// - Not-stopped indication goes to enable logic.
// - Speed flag drives general output one.
// - Demand clamped +-300 percent, speed-loop source default.
// - Zero level 0 to 100 percent, default 2.
// - Hold enable defaults to disabled.
// - Zero level also switches the zero-speed relay.
// - Feedback comes from the feedback percent input.
module mszd_standstill #(
    parameter SAMPLE_CYCLES = `MSZD_SAMPLE_CYCLES
)(
    input wire clk,
    input wire reset_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire [15:0] feedback_speed_pct,
    input wire [15:0] speed_loop_demand,
    output reg speed_near_zero_flag,
    output reg demand_near_zero_flag,
    output wire motor_stopped_flag,
    output wire not_stopped,
    output wire general_output_one,
    output wire zero_speed_relay,
    output wire speed_loop_quench,
    output wire current_loop_quench,
    output wire firing_inhibit,
    output wire contactor_keep,
    output wire run_lamp_keep,
    output wire irq
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Magnitude of a signed hundredths value, one bit wider so that the
    // most negative code cannot wrap back to a small number.
    function [16:0] mag;
        input [15:0] v;
        begin
            if (v[15])
                mag = 17'h00000 - {v[15], v};
            else
                mag = {1'b0, v};
        end
    endfunction

    // One hysteresis comparator: set below the level, clear only above
    // level plus band, hold in between.
    function cmp_hyst;
        input old;
        input [16:0] val;
        input [16:0] lvl;
        begin
            if (val < lvl)
                cmp_hyst = 1'b1;
            else if (val > lvl + `MSZD_HYSTERESIS)
                cmp_hyst = 1'b0;
            else
                cmp_hyst = old;
        end
    endfunction

    // Limit a signed demand word to the documented span.
    function [15:0] clamp_demand;
        input [15:0] v;
        begin
            if (!v[15] && v > `MSZD_DEMAND_MAX)
                clamp_demand = `MSZD_DEMAND_MAX;
            else if (v[15] && mag(v) > {1'b0, `MSZD_DEMAND_MAX})
                clamp_demand = 16'h0000 - `MSZD_DEMAND_MAX;
            else
                clamp_demand = v;
        end
    endfunction

    // ****************************************************************
    // Registers and state
    // ****************************************************************

    reg [1:0] ctrl; // Hold enable and demand source select.
    reg [15:0] zero_level; // Zero level, hundredths of a percent.
    reg [15:0] demand_sw; // Software demand value.
    reg [2:0] irq_status; // Sticky event bits.
    reg [2:0] irq_enable; // Event mask, one enables.
    reg hold_active; // Stop-hold is in force.
    reg stopped_q; // Stopped flag one clock ago.
    reg [15:0] div_cnt; // Sample divider count.
    reg sample_tick; // One-cycle pulse per sample.
    reg dp_write; // A write data phase is pending.
    reg [5:0] dp_addr; // Address latched in the address phase.
    reg [31:0] next_rdata; // Read data chosen at the address phase.
    reg [2:0] next_irq_status; // Sticky bits after set and clear.
    wire [15:0] demand_src; // Demand actually compared.
    wire [2:0] events; // This cycle's events.
    wire addr_ok; // Address phase taken this cycle.

    // Single-cycle slave: every transfer completes without wait states.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && hready && htrans[1];

    // ****************************************************************
    // Sample divider
    // ****************************************************************

    // The comparators run on a slower control sample so the flags do not
    // chatter on every bus-clock step of a noisy feedback word.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_cnt <= 16'h0000;
            sample_tick <= 1'b0;
        end
        else if (div_cnt == SAMPLE_CYCLES[15:0] - 16'h0001)
        begin
            div_cnt <= 16'h0000;
            sample_tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 16'h0001;
            sample_tick <= 1'b0;
        end
    end

    // ****************************************************************
    // Comparators and standstill logic
    // ****************************************************************

    // Demand follows the speed loop unless software overrides it.
    assign demand_src = ctrl[`MSZD_CTRL_DEMAND_SW] ? demand_sw :
                        clamp_demand(speed_loop_demand);

    // Both flags update only on a sample tick and reset to false.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            speed_near_zero_flag <= 1'b0;
            demand_near_zero_flag <= 1'b0;
        end
        else if (sample_tick)
        begin
            // Feedback is the feedback block's percent word.
            speed_near_zero_flag <= cmp_hyst(speed_near_zero_flag,
                mag(feedback_speed_pct), {1'b0, zero_level});
            demand_near_zero_flag <= cmp_hyst(demand_near_zero_flag,
                mag(demand_src), {1'b0, zero_level});
        end
    end

    // Stopped is purely the AND of the two flags.
    assign motor_stopped_flag = speed_near_zero_flag &&
                                demand_near_zero_flag;
    assign not_stopped = !motor_stopped_flag;
    assign general_output_one = speed_near_zero_flag;
    // The relay switches at the same programmed zero level.
    assign zero_speed_relay = speed_near_zero_flag;

    // Hold follows stopped while enabled; it drops one clock after either
    // flag drops, since stopped drops with it.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_active <= 1'b0;
            stopped_q <= 1'b0;
        end
        else
        begin
            hold_active <= motor_stopped_flag &&
                           ctrl[`MSZD_CTRL_HOLD_EN];
            stopped_q <= motor_stopped_flag;
        end
    end

    // Quench loops and gate firing, but keep the contactor and lamp.
    assign speed_loop_quench = hold_active;
    assign current_loop_quench = hold_active;
    assign firing_inhibit = hold_active;
    assign contactor_keep = hold_active;
    assign run_lamp_keep = hold_active;

    // ****************************************************************
    // Interrupts
    // ****************************************************************

    assign events[`MSZD_EV_STOP_ENTER] = motor_stopped_flag && !stopped_q;
    assign events[`MSZD_EV_STOP_LEAVE] = !motor_stopped_flag && stopped_q;
    assign events[`MSZD_EV_HOLD_ENTER] = motor_stopped_flag &&
        ctrl[`MSZD_CTRL_HOLD_EN] && !hold_active;

    // A clear write loses to an event in the same cycle, so no event is
    // ever dropped by a racing clear.
    always @*
    begin
        next_irq_status = irq_status;
        if (dp_write && dp_addr == `MSZD_ADDR_IRQ_CLEAR)
            next_irq_status = next_irq_status & ~hwdata[2:0];
        next_irq_status = next_irq_status | events;
    end

    assign irq = |(irq_status & irq_enable);

    // ****************************************************************
    // AHB-Lite register slave
    // ****************************************************************

    // Read data is picked from the address phase so that hrdata comes
    // straight from a flip-flop in the data phase.
    always @*
    begin
        next_rdata = 32'h00000000;
        case (haddr[5:0])
            `MSZD_ADDR_CTRL: next_rdata = {30'h00000000, ctrl};
            `MSZD_ADDR_ZERO_LEVEL: next_rdata = {16'h0000, zero_level};
            `MSZD_ADDR_DEMAND_SW: next_rdata = {16'h0000, demand_sw};
            `MSZD_ADDR_STATUS:
                next_rdata = {28'h0000000, hold_active, motor_stopped_flag,
                              demand_near_zero_flag, speed_near_zero_flag};
            `MSZD_ADDR_IRQ_STATUS: next_rdata = {29'h00000000, irq_status};
            `MSZD_ADDR_IRQ_ENABLE: next_rdata = {29'h00000000, irq_enable};
            `MSZD_ADDR_FEEDBACK:
                next_rdata = {16'h0000, feedback_speed_pct};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Address phase capture, read data and register writes.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dp_write <= 1'b0;
            dp_addr <= 6'h00;
            hrdata <= 32'h00000000;
            ctrl <= `MSZD_CTRL_RESET;
            zero_level <= `MSZD_ZERO_LEVEL_RESET;
            demand_sw <= `MSZD_DEMAND_SW_RESET;
            irq_status <= 3'h0;
            irq_enable <= 3'h0;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (hready)
            begin
                dp_write <= addr_ok && hwrite;
                dp_addr <= haddr[5:0];
                if (addr_ok && !hwrite)
                    hrdata <= haddr[31:6] == 26'h0000000 ? next_rdata :
                              32'h00000000;
            end
            // Writes land at the end of the data phase; unmapped and
            // read-only offsets are ignored.
            if (dp_write)
            begin
                case (dp_addr)
                    `MSZD_ADDR_CTRL: ctrl <= hwdata[1:0];
                    `MSZD_ADDR_ZERO_LEVEL:
                    begin
                        // Values past 100 percent are clipped.
                        if (hwdata[15:0] > `MSZD_ZERO_LEVEL_MAX)
                            zero_level <= `MSZD_ZERO_LEVEL_MAX;
                        else
                            zero_level <= hwdata[15:0];
                    end
                    `MSZD_ADDR_DEMAND_SW:
                        demand_sw <= clamp_demand(hwdata[15:0]);
                    `MSZD_ADDR_IRQ_ENABLE: irq_enable <= hwdata[2:0];
                    // Clear, status and unmapped offsets store nothing
                    // here; touching dp_write would drop a write that
                    // is taken in this same cycle.
                    default: ;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// >>> shared/mszd_defines.vh
// Constants for the motor standstill detector: register offsets, field
// positions, reset values, value ranges and the sampling period.
// Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef MSZD_DEFINES_VH
`define MSZD_DEFINES_VH

// Register byte offsets.
`define MSZD_ADDR_CTRL 6'h00
`define MSZD_ADDR_ZERO_LEVEL 6'h04
`define MSZD_ADDR_DEMAND_SW 6'h08
`define MSZD_ADDR_STATUS 6'h0c
`define MSZD_ADDR_IRQ_STATUS 6'h10
`define MSZD_ADDR_IRQ_CLEAR 6'h14
`define MSZD_ADDR_IRQ_ENABLE 6'h18
`define MSZD_ADDR_FEEDBACK 6'h1c

// Control register fields.
`define MSZD_CTRL_HOLD_EN 0
`define MSZD_CTRL_DEMAND_SW 1

// Status register fields.
`define MSZD_ST_SPEED_ZERO 0
`define MSZD_ST_DEMAND_ZERO 1
`define MSZD_ST_STOPPED 2
`define MSZD_ST_HOLD 3

// Interrupt event fields.
`define MSZD_EV_STOP_ENTER 0
`define MSZD_EV_STOP_LEAVE 1
`define MSZD_EV_HOLD_ENTER 2

// Reset values; levels are in hundredths of a percent.
`define MSZD_CTRL_RESET 2'h0
`define MSZD_ZERO_LEVEL_RESET 16'h00c8
`define MSZD_DEMAND_SW_RESET 16'h0000

// Ranges and hysteresis, in hundredths of a percent.
`define MSZD_ZERO_LEVEL_MAX 16'h2710
`define MSZD_DEMAND_MAX 16'h7530
`define MSZD_HYSTERESIS 17'h00032

// Sampling period of the comparators.
`define MSZD_SAMPLE_NS 1000
`define MSZD_CLK_NS 50
`define MSZD_SAMPLE_CYCLES (`MSZD_SAMPLE_NS / `MSZD_CLK_NS)

`endif

// >>> tb/mszd_asserts.sv
// Checker for the standstill detector, bound to the top module.
// Assumes it sees only the top module's ports, clocked by clk.
`include "mszd_defines.vh"
`default_nettype none
module mszd_asserts #(
    parameter SAMPLE_CYCLES = 20
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] feedback_speed_pct,
    input wire logic speed_near_zero_flag,
    input wire logic demand_near_zero_flag,
    input wire logic motor_stopped_flag,
    input wire logic not_stopped,
    input wire logic general_output_one,
    input wire logic zero_speed_relay,
    input wire logic speed_loop_quench,
    input wire logic current_loop_quench,
    input wire logic firing_inhibit,
    input wire logic contactor_keep,
    input wire logic run_lamp_keep,
    input wire logic irq
);
    // Magnitude of the feedback, since the compare ignores direction.
    logic [15:0] fb_mag;
    assign fb_mag = feedback_speed_pct[15] ? 16'h0 - feedback_speed_pct :
        feedback_speed_pct;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_stop_both: assert property (motor_stopped_flag ==
        (speed_near_zero_flag && demand_near_zero_flag)) else $error("stop");
    a_not_stop_inv: assert property (not_stopped != motor_stopped_flag)
        else $error("not stopped");
    a_gpo_speed: assert property (general_output_one ==
        speed_near_zero_flag) else $error("output one");
    a_relay_speed: assert property (zero_speed_relay ==
        speed_near_zero_flag) else $error("relay");
    a_quench_pair: assert property (speed_loop_quench ==
        current_loop_quench) else $error("quench pair");
    a_hold_outs: assert property ({firing_inhibit, contactor_keep,
        run_lamp_keep} == {3{speed_loop_quench}}) else $error("hold outs");
    a_hold_cause: assert property ($rose(speed_loop_quench) |->
        $past(motor_stopped_flag)) else $error("hold cause");
    a_hold_drop: assert property (!motor_stopped_flag [*2] |->
        !speed_loop_quench) else $error("hold drop");
    a_speed_set: assert property ($rose(speed_near_zero_flag) |->
        $past(fb_mag) < `MSZD_ZERO_LEVEL_MAX) else $error("speed set");
    a_speed_clr: assert property ($fell(speed_near_zero_flag) |->
        $past(fb_mag) > 16'h0032) else $error("speed clear");
    c_stop: cover property ($rose(motor_stopped_flag));
    c_hold: cover property ($rose(speed_loop_quench));
    c_irq: cover property ($rose(irq));
endmodule
bind mszd_standstill mszd_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
    .clk(clk), .reset_n(reset_n), .feedback_speed_pct(feedback_speed_pct),
    .speed_near_zero_flag(speed_near_zero_flag), .irq(irq),
    .demand_near_zero_flag(demand_near_zero_flag),
    .motor_stopped_flag(motor_stopped_flag), .not_stopped(not_stopped),
    .general_output_one(general_output_one),
    .zero_speed_relay(zero_speed_relay),
    .speed_loop_quench(speed_loop_quench),
    .current_loop_quench(current_loop_quench),
    .firing_inhibit(firing_inhibit), .contactor_keep(contactor_keep),
    .run_lamp_keep(run_lamp_keep));
`default_nettype wire

// >>> tb/mszd_drive_model.sv
// Model of the speed loop and feedback block feeding the detector.
// Assumes the bench commands speed and demand in hundredths of a percent.
`default_nettype none
module mszd_drive_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] cmd_speed,
    input wire logic [15:0] cmd_demand,
    output logic [15:0] feedback_speed_pct,
    output logic [15:0] speed_loop_demand
);
    // Both values pass a register, as a real loop updates once a cycle.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            feedback_speed_pct <= 16'h0000;
            speed_loop_demand <= 16'h0000;
        end
        else
        begin
            feedback_speed_pct <= cmd_speed;
            speed_loop_demand <= cmd_demand;
        end
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench: AHB-Lite master tasks and one task per scenario.
// Assumes the detector runs with a short sampling period of 4 cycles.
`include "mszd_defines.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 4;
    logic clk = 0, reset_n = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] cmd_speed = 0, cmd_demand = 0, fb, dem;
    wire hreadyout, szf, dzf, msf, nst, gpo, rly, slq, clq, fin, ck, rl, irq;
    wire [31:0] hrdata;
    wire hrsp;
    int fails = 0, n_checks = 0;
    always #25 clk = ~clk;
    mszd_drive_model u_drv (.clk(clk), .reset_n(reset_n),
        .cmd_speed(cmd_speed), .cmd_demand(cmd_demand),
        .feedback_speed_pct(fb), .speed_loop_demand(dem));
    mszd_standstill #(.SAMPLE_CYCLES(SC)) DUT (.clk(clk), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hrsp), .hrdata(hrdata),
        .feedback_speed_pct(fb), .speed_loop_demand(dem),
        .speed_near_zero_flag(szf), .demand_near_zero_flag(dzf),
        .motor_stopped_flag(msf), .not_stopped(nst),
        .general_output_one(gpo), .zero_speed_relay(rly),
        .speed_loop_quench(slq), .current_loop_quench(clq),
        .firing_inhibit(fin), .contactor_keep(ck), .run_lamp_keep(rl),
        .irq(irq));
    // One single-word transfer; the wait ends only on hready.
    task automatic bus(input logic wr, input logic [5:0] a,
        input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1;
        haddr <= {26'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Two full sample periods plus three cycles, covering the model's register stage.
    task automatic settle();
        repeat (2 * SC + 3) @(posedge clk);
        #1;
    endtask
    task automatic rdchk(input string nm, input logic [5:0] a,
        input logic [31:0] e);
        bus(0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic t_reset();
        chk("outs", 32'h1, {slq, irq, msf, nst});
        chk("hresp", 32'h0, hrsp);
        rdchk("ctrl", `MSZD_ADDR_CTRL, 32'h0);
        rdchk("level", `MSZD_ADDR_ZERO_LEVEL, 32'h00c8);
    endtask
    task automatic t_hyst();
        cmd_speed <= 16'h0096;
        cmd_demand <= 16'h0096;
        settle();
        chk("stop", 32'h1f, {szf, dzf, msf, gpo, rly});
        chk("nst", 32'h0, {nst, slq});
        rdchk("status", `MSZD_ADDR_STATUS, 32'h7);
        cmd_speed <= 16'h00e6;
        settle();
        chk("band", 32'h1, szf);
        cmd_speed <= 16'h00fb;
        settle();
        chk("clear", 32'h0, {szf, msf, gpo});
        cmd_speed <= 16'h00e6;
        settle();
        chk("band low", 32'h0, szf);
    endtask
    task automatic t_hold();
        bus(1, `MSZD_ADDR_IRQ_CLEAR, 32'h7);
        bus(1, `MSZD_ADDR_CTRL, 32'h1);
        cmd_speed <= 16'h0000;
        cmd_demand <= 16'h0000;
        settle();
        chk("quench", 32'h1f, {slq, clq, fin, ck, rl});
        chk("masked", 32'h0, irq);
        rdchk("status", `MSZD_ADDR_STATUS, 32'hf);
        rdchk("events", `MSZD_ADDR_IRQ_STATUS, 32'h5);
        bus(1, `MSZD_ADDR_IRQ_ENABLE, 32'h7);
        settle();
        chk("irq on", 32'h1, irq);
        cmd_demand <= 16'h012c;
        settle();
        chk("drop", 32'h0, {slq, clq, fin, msf});
        rdchk("events", `MSZD_ADDR_IRQ_STATUS, 32'h7);
        bus(1, `MSZD_ADDR_IRQ_CLEAR, 32'h7);
        settle();
        chk("irq off", 32'h0, irq);
    endtask
    task automatic t_regs();
        bus(1, `MSZD_ADDR_ZERO_LEVEL, 32'h3000);
        rdchk("clip", `MSZD_ADDR_ZERO_LEVEL, 32'h2710);
        bus(1, `MSZD_ADDR_DEMAND_SW, 32'h7fff);
        rdchk("dclip", `MSZD_ADDR_DEMAND_SW, 32'h7530);
        bus(1, `MSZD_ADDR_DEMAND_SW, 32'h8000);
        rdchk("dneg", `MSZD_ADDR_DEMAND_SW, 32'h8ad0);
        bus(1, `MSZD_ADDR_DEMAND_SW, 32'h0);
        // Back to the default level, so that the loop demand of 300
        // would clear the flag and only the software source sets it.
        bus(1, `MSZD_ADDR_ZERO_LEVEL, 32'hc8);
        bus(1, `MSZD_ADDR_CTRL, 32'h2);
        cmd_speed <= 16'h0123;
        settle();
        chk("dsw", 32'h1, {szf, dzf});
        rdchk("fb", `MSZD_ADDR_FEEDBACK, 32'h0123);
        rdchk("unmapped", 6'h3c, 32'h0);
    endtask
    // Reset in mid-run while stopped: every flag, the control word and the zero
    // level must fall back, and a negative feedback must count by its magnitude.
    task automatic t_rst2();
        cmd_speed <= 16'hff9c;
        settle();
        chk("pre", 32'h7, {szf, dzf, msf});
        @(posedge clk);
        reset_n <= 0;
        repeat (2) @(posedge clk);
        #1;
        chk("rst outs", 32'h1, {szf, dzf, msf, slq, irq, nst});
        @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        #1;
        rdchk("ctrl2", `MSZD_ADDR_CTRL, 32'h0);
        rdchk("level2", `MSZD_ADDR_ZERO_LEVEL, 32'h00c8);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        #1;
        t_reset();
        t_hyst();
        t_hold();
        t_regs();
        t_rst2();
        stop_test();
    end
    // Watchdog: the scenarios need far fewer than this many cycles.
    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
